/* core/flash_pwr_consts.svh */
// Timing constants and opcodes for the flash power-state controller
`ifndef FLASH_PWR_CONSTS_SVH
`define FLASH_PWR_CONSTS_SVH
`define CLK_PERIOD_NS 10
`define SELECT_DELAY_US 30
`define SELECT_DELAY_CYC ((`SELECT_DELAY_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PUW_DELAY_MS 10
`define PUW_DELAY_CYC (`PUW_DELAY_MS * 1000000 / `CLK_PERIOD_NS)
`define WAKE_DELAY_CYC 300
`define OP_WAKE 8'hAB
`define OP_SLEEP 8'hB9
`define OP_WRITE_ENABLE_CMD 8'h06
`define OP_PROG 8'h02
`define OP_DPROG 8'hA2
`define OP_OTP 8'h42
`define OP_SSE 8'h20
`define OP_BLK 8'hD8
`define OP_FULL 8'hC7
`define OP_SWR 8'h01
`define OP_LWR 8'hE5
`define STATUS_RESET 8'h00
`endif

/* core/flash_pwr_pkg.sv */
// Types for the flash power-state controller
`default_nettype none
package flash_pwr_pkg;
    typedef enum logic [1:0] {
        st_standby = 2'b00,
        st_sleep = 2'b01,
        st_waking = 2'b10
    } pwr_state_type;
    typedef struct packed {
        logic write_enable_latch;
        logic busy_flag;
        logic [1:0] lock_bits;
    } status_type;
endpackage
`default_nettype wire

/* core/frame_decoder.sv */
// Serial frame sampler: synchronises the link pins and shifts the opcode
`default_nettype none
module frame_decoder
    import flash_pwr_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic sel_n_pin,
    input wire logic sclk_pin,
    input wire logic serial_data_in,
    output logic frame_end,
    output logic frame_start,
    output logic [7:0] opcode,
    output logic [5:0] bit_count,
    output logic selected
);
    logic [2:0] s_meta;
    logic [2:0] s_sync;
    logic sclk_d;
    logic sel_d;
    wire sel_n_s = s_sync[0];
    wire sclk_s = s_sync[1];
    wire data_s = s_sync[2];
    wire sclk_rise = sclk_s & ~sclk_d;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            s_meta <= 3'h1;
            s_sync <= 3'h1;
            sclk_d <= 1'b0;
            sel_d <= 1'b0;
        end else begin
            s_meta <= {serial_data_in, sclk_pin, sel_n_pin};
            s_sync <= s_meta;
            sclk_d <= sclk_s;
            sel_d <= ~sel_n_s;
        end
    end
    assign selected = sel_d;
    assign frame_start = ~sel_n_s & ~sel_d;
    assign frame_end = sel_n_s & sel_d;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            opcode <= 8'h00;
            bit_count <= 6'h00;
        end else if (frame_start) begin
            opcode <= 8'h00;
            bit_count <= 6'h00;
        end else if (sel_d && sclk_rise) begin
            if (bit_count < 6'h08)
                opcode <= {opcode[6:0], data_s};
            if (bit_count != 6'h3F)
                bit_count <= bit_count + 6'h01;
        end
    end
endmodule
`default_nettype wire

/* core/flash_pwr_ctrl.sv */
// Power-state and power-up instruction gating for a serial flash
`include "flash_pwr_consts.svh"
`default_nettype none
// Summary of operation
// - In deep sleep every instruction but the wake code is discarded.
// - Extra clock edges after the wake code reject it; device stays asleep.
// - Wake completes on select rising; standby after the wake delay.
// - Wake code during a running cycle is rejected, cycle unaffected.
// - Logic held reset, silent, while supply is below inhibit threshold.
// - Write-type instructions ignored until power-up write delay expires.
// - Reads accepted once select delay passes, even inside write delay.
// - Power-up gives standby, clear write latch, busy and lock bits.
// - Below threshold at power-down all operations stop at once.
// - Delivered status register: write latch in bit 1, busy in bit 0, upper bits zero.
// - Deep sleep entered only by the sleep instruction.
module flash_pwr_ctrl
    import flash_pwr_pkg::*;
#(
    parameter int PUW_CYCLES = `PUW_DELAY_CYC,
    parameter int VSL_CYCLES = `SELECT_DELAY_CYC,
    parameter int WAKE_CYCLES = `WAKE_DELAY_CYC
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic sel_n_pin,
    input wire logic sclk_pin,
    input wire logic serial_data_in,
    input wire logic cycle_busy,
    output logic in_sleep,
    output logic standby,
    output logic write_allowed,
    output logic read_allowed,
    output logic cmd_valid,
    output logic [7:0] cmd_code,
    output logic [7:0] status_out
);
    pwr_state_type state;
    pwr_state_type next_state;
    status_type status;
    logic [31:0] puw_cnt;
    logic [31:0] vsl_cnt;
    logic [31:0] wake_cnt;
    logic frame_end;
    logic frame_start;
    logic selected;
    logic [7:0] opcode;
    logic [5:0] bit_count;

    frame_decoder u_dec (
        .clock(clock),
        .sys_rst(sys_rst),
        .sel_n_pin(sel_n_pin),
        .sclk_pin(sclk_pin),
        .serial_data_in(serial_data_in),
        .frame_end(frame_end),
        .frame_start(frame_start),
        .opcode(opcode),
        .bit_count(bit_count),
        .selected(selected)
    );

    wire exact8 = bit_count == 6'h08;
    wire wake_ok = frame_end && exact8 && opcode == `OP_WAKE
        && !cycle_busy;
    wire sleep_ok = frame_end && exact8 && opcode == `OP_SLEEP
        && !cycle_busy;
    wire is_write = opcode == `OP_WRITE_ENABLE_CMD || opcode == `OP_PROG
        || opcode == `OP_DPROG || opcode == `OP_OTP
        || opcode == `OP_SSE || opcode == `OP_BLK
        || opcode == `OP_FULL || opcode == `OP_SWR
        || opcode == `OP_LWR;
    wire cmd_is_write = cmd_code == `OP_WRITE_ENABLE_CMD || cmd_code == `OP_PROG
        || cmd_code == `OP_DPROG || cmd_code == `OP_OTP
        || cmd_code == `OP_SSE || cmd_code == `OP_BLK
        || cmd_code == `OP_FULL || cmd_code == `OP_SWR
        || cmd_code == `OP_LWR;
    wire puw_done = puw_cnt >= PUW_CYCLES;
    wire vsl_done = vsl_cnt >= VSL_CYCLES;
    wire wake_done = wake_cnt >= WAKE_CYCLES;
    wire pass_cmd = frame_end && bit_count >= 6'h08
        && state == st_standby && vsl_done
        && (!is_write || puw_done);
    wire next_wel = pass_cmd && opcode == `OP_WRITE_ENABLE_CMD;

    always_comb begin
        next_state = state;
        unique case (state)
            st_standby: if (sleep_ok) next_state = st_sleep;
            st_sleep: if (wake_ok) next_state = st_waking;
            st_waking: if (wake_done) next_state = st_standby;
            default: next_state = st_standby;
        endcase
    end

    // Power-on reset is sys_rst: it clears everything
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state <= st_standby;
            puw_cnt <= 32'h0;
            vsl_cnt <= 32'h0;
            wake_cnt <= 32'h0;
        end else begin
            state <= next_state;
            if (!puw_done)
                puw_cnt <= puw_cnt + 32'h1;
            if (!vsl_done)
                vsl_cnt <= vsl_cnt + 32'h1;
            if (state == st_waking)
                wake_cnt <= wake_cnt + 32'h1;
            else
                wake_cnt <= 32'h0;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            status <= '0;
            cmd_valid <= 1'b0;
            cmd_code <= 8'h00;
        end else begin
            cmd_valid <= pass_cmd;
            cmd_code <= pass_cmd ? opcode : cmd_code;
            status.busy_flag <= cycle_busy;
            if (next_wel)
                status.write_enable_latch <= 1'b1;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            in_sleep <= 1'b0;
            standby <= 1'b1;
            write_allowed <= 1'b0;
            read_allowed <= 1'b0;
            status_out <= `STATUS_RESET;
        end else begin
            in_sleep <= next_state == st_sleep;
            standby <= next_state == st_standby;
            write_allowed <= puw_done && vsl_done;
            read_allowed <= vsl_done;
            status_out <= {6'h00, status.write_enable_latch,
                status.busy_flag};
        end
    end

    chk_wake_rejected: assert property (
        @(posedge clock) disable iff (sys_rst)
        state == st_sleep && frame_end && !exact8
        |=> state == st_sleep)
        else $error("wake with extra clocks was accepted");
    chk_wake_busy: assert property (
        @(posedge clock) disable iff (sys_rst)
        state == st_sleep && cycle_busy |=> state == st_sleep)
        else $error("wake accepted during running cycle");
    chk_sleep_ignore: assert property (
        @(posedge clock) disable iff (sys_rst)
        state == st_sleep |=> !cmd_valid)
        else $error("instruction passed while asleep");
    chk_wake_time: assert property (
        @(posedge clock) disable iff (sys_rst)
        state == st_sleep && wake_ok |=> state == st_waking
        ##WAKE_CYCLES state == st_waking ##1 state == st_standby)
        else $error("wake delay wrong");
    chk_write_gate: assert property (
        @(posedge clock) disable iff (sys_rst)
        cmd_valid && !write_allowed |-> !(cmd_code == `OP_WRITE_ENABLE_CMD))
        else $error("write passed inside power-up delay");
    chk_sleep_entry: assert property (
        @(posedge clock) disable iff (sys_rst)
        $rose(in_sleep) |-> $past(sleep_ok))
        else $error("sleep without sleep instruction");
    chk_read_gate: assert property (
        @(posedge clock) disable iff (sys_rst)
        cmd_valid |-> read_allowed || $past(vsl_done))
        else $error("command before select delay");
    chk_reset_state: assert property (
        @(posedge clock)
        sys_rst |=> !in_sleep && status_out == 8'h00)
        else $error("bad power-up state");
    chk_write_gate_all: assert property (
        @(posedge clock) disable iff (sys_rst)
        cmd_valid && cmd_is_write |-> write_allowed)
        else $error("write type passed inside power-up delay");
    chk_read_accept: assert property (
        @(posedge clock) disable iff (sys_rst)
        frame_end && exact8 && state == st_standby && vsl_done && !is_write
        |=> cmd_valid && cmd_code == $past(opcode))
        else $error("read refused after select delay");
    chk_waking_silent: assert property (
        @(posedge clock) disable iff (sys_rst)
        state == st_waking |=> !cmd_valid && !in_sleep)
        else $error("instruction taken during wake delay");
    chk_powerup_state: assert property (
        @(posedge clock) $past(sys_rst) && !sys_rst
        |-> standby && !in_sleep && !write_allowed && !cmd_valid)
        else $error("power-up state not standby");
    chk_cmd_pulse: assert property (
        @(posedge clock) disable iff (sys_rst)
        cmd_valid |=> !cmd_valid)
        else $error("one frame answered twice");
    chk_sleep_hold: assert property (
        @(posedge clock) disable iff (sys_rst)
        state == st_sleep && !wake_ok |=> state == st_sleep && in_sleep)
        else $error("left deep sleep without wake code");
    chk_standby_hold: assert property (
        @(posedge clock) disable iff (sys_rst)
        state == st_standby && !sleep_ok |=> !in_sleep)
        else $error("deep sleep entered without sleep code");
    chk_answer_deselected: assert property (
        @(posedge clock) disable iff (sys_rst)
        cmd_valid |-> !selected)
        else $error("instruction answered while still selected");
    cov_sleep: cover property (@(posedge clock) $rose(in_sleep));
    cov_wake: cover property (@(posedge clock) state == st_waking);
    cov_write: cover property (@(posedge clock) cmd_valid && write_allowed);
    cov_frame: cover property (@(posedge clock) frame_start);
    cov_reject: cover property (@(posedge clock)
        state == st_sleep && frame_end && !exact8);
endmodule
`default_nettype wire

/* verification/spi_host_model.sv */
// Host model driving the serial link toward the flash block
`default_nettype none
module spi_host_model (
    input wire logic clock,
    output logic sel_n_pin,
    output logic sclk_pin,
    output logic serial_data_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sel_n_pin = 1'b1;
        sclk_pin = 1'b0;
        serial_data_in = 1'b0;
    end
    // Frame of n clock edges, opcode MSB first
    task automatic send(input logic [7:0] op, input int n);
        logic [8:0] sh;
        sh = {op, 1'b0};
        @(posedge clock) #1 sel_n_pin = 1'b0;
        for (int i = 0; i < n; i++) begin
            serial_data_in = sh[8];
            sh = sh << 1;
            #80 sclk_pin = 1'b1;
            #80 sclk_pin = 1'b0;
        end
        #80 sel_n_pin = 1'b1;
        serial_data_in = ~serial_data_in;
    endtask
endmodule
`default_nettype wire

/* verification/tb_top.sv */
// Testbench for the flash power-state controller
`include "flash_pwr_consts.svh"
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
    error_cnt++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic cycle_busy = 1'b0;
    logic sel_n_pin, sclk_pin, serial_data_in;
    logic in_sleep, standby, write_allowed, read_allowed, cmd_valid;
    logic [7:0] cmd_code, status_out;
    int error_cnt = 0;
    int n_tests = 0;
    int pulses = 0;
    int p0;
    logic [7:0] wr_ops[9] = '{`OP_WRITE_ENABLE_CMD, `OP_PROG, `OP_DPROG, `OP_OTP,
        `OP_SSE, `OP_BLK, `OP_FULL, `OP_SWR, `OP_LWR};
    spi_host_model u_host (.clock(clock), .sel_n_pin(sel_n_pin),
        .sclk_pin(sclk_pin), .serial_data_in(serial_data_in));
    flash_pwr_ctrl #(.PUW_CYCLES(2000), .VSL_CYCLES(50),
        .WAKE_CYCLES(20)) u_dut (.clock(clock), .sys_rst(sys_rst),
        .sel_n_pin(sel_n_pin), .sclk_pin(sclk_pin),
        .serial_data_in(serial_data_in), .cycle_busy(cycle_busy),
        .in_sleep(in_sleep), .standby(standby),
        .write_allowed(write_allowed), .read_allowed(read_allowed),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .status_out(status_out));
    initial begin
        forever #5 clock = ~clock;
    end
    always @(posedge clock) begin
        if (cmd_valid === 1'b1) pulses++;
    end
    task automatic frame(input logic [7:0] op, input int n);
        u_host.send(op, n);
        repeat (8) @(posedge clock);
        #1;
    endtask
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic t_reset();
        `CHK("sleep", 1'b0, in_sleep)
        `CHK("standby", 1'b1, standby)
        `CHK("wr_ok", 1'b0, write_allowed)
        `CHK("rd_ok", 1'b0, read_allowed)
        `CHK("status", `STATUS_RESET, status_out)
        `CHK("no answer", 1'b0, cmd_valid)
        $display("reset test done");
    endtask
    task automatic t_early();
        repeat (60) @(posedge clock);
        #1;
        `CHK("rd_ok", 1'b1, read_allowed)
        `CHK("wr_ok", 1'b0, write_allowed)
        p0 = pulses;
        foreach (wr_ops[i]) frame(wr_ops[i], 8);
        `CHK("wr pulses", p0, pulses)
        frame(8'h03, 8);
        `CHK("rd pulse", p0 + 1, pulses)
        `CHK("rd code", 8'h03, cmd_code)
        $display("early test done");
    endtask
    task automatic t_write();
        for (int i = 0; i < 800 && write_allowed !== 1'b1; i++)
            @(posedge clock);
        #1;
        `CHK("wr_ok", 1'b1, write_allowed)
        frame(`OP_WRITE_ENABLE_CMD, 8);
        `CHK("write_enable_cmd code", `OP_WRITE_ENABLE_CMD, cmd_code)
        `CHK("latch", 8'h02, status_out)
        p0 = pulses;
        foreach (wr_ops[i]) frame(wr_ops[i], 8);
        `CHK("wr pass", p0 + 9, pulses)
        $display("write test done");
    endtask
    task automatic t_sleep();
        frame(`OP_SLEEP, 8);
        `CHK("asleep", 1'b1, in_sleep)
        p0 = pulses;
        frame(8'h03, 8);
        `CHK("ignored", p0, pulses)
        frame(`OP_WAKE, 9);
        `CHK("extra edge", 1'b1, in_sleep)
        cycle_busy = 1'b1;
        frame(`OP_WAKE, 8);
        `CHK("busy wake", 1'b1, in_sleep)
        `CHK("busy bit", 8'h03, status_out)
        cycle_busy = 1'b0;
        frame(`OP_WAKE, 8);
        `CHK("woken", 1'b0, in_sleep)
        `CHK("waking", 1'b0, standby)
        repeat (22) @(posedge clock);
        #1;
        `CHK("standby", 1'b1, standby)
        $display("sleep test done");
    endtask
    task automatic t_power_down();
        frame(`OP_SLEEP, 8);
        sys_rst = 1'b1;
        repeat (2) @(posedge clock);
        #1;
        `CHK("pd sleep", 1'b0, in_sleep)
        `CHK("pd wr_ok", 1'b0, write_allowed)
        `CHK("pd standby", 1'b1, standby)
        `CHK("pd status", `STATUS_RESET, status_out)
        sys_rst = 1'b0;
        $display("power-down test done");
    endtask
    initial begin
        repeat (6) @(posedge clock);
        #1;
        t_reset();
        sys_rst = 1'b0;
        t_early();
        t_write();
        t_sleep();
        t_power_down();
        conclude();
    end
    initial begin
        #100us;
        error_cnt++;
        conclude();
    end
endmodule
`default_nettype wire
